//--- rtl/tims_pkg.sv
// Register map, field positions and reset values of the timer interrupt block
package tims_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NSRC = 14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_RAW_STATUS = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASKED_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_MODE_CTRL = 8'h28;
  localparam logic [NSRC-1:0] IRQ_RESET = 14'h0000;
  localparam logic [NSRC-1:0] IRQ_IMPL_BITS = 14'h2F37;
  localparam int SUB_A_TIMEOUT = 0;
  localparam int SUB_A_CAP_MATCH = 1;
  localparam int SUB_A_CAP_EVENT = 2;
  localparam int SUB_A_MATCH = 4;
  localparam int SUB_A_DMA_DONE = 5;
  localparam int SUB_B_TIMEOUT = 8;
  localparam int SUB_B_CAP_MATCH = 9;
  localparam int SUB_B_CAP_EVENT = 10;
  localparam int SUB_B_MATCH = 11;
  localparam int SUB_B_DMA_DONE = 13;
  // Mode control register: per sub-timer mode bits
  localparam int MODE_A_PERIODIC = 0;
  localparam int MODE_A_EDGE_TIME = 1;
  localparam int MODE_A_MATCH_ALLOW = 2;
  localparam int MODE_B_PERIODIC = 8;
  localparam int MODE_B_EDGE_TIME = 9;
  localparam int MODE_B_MATCH_ALLOW = 10;
  localparam logic [DATA_W-1:0] MODE_IMPL_BITS = 32'h0000_0707;
  localparam logic [DATA_W-1:0] MODE_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
endpackage : tims_pkg

//--- rtl/tims_sub_events.sv
// Event qualification for one sub-timer
`timescale 1ns/100ps
`default_nettype none
module tims_sub_events (
  input wire logic periodic_mode,
  input wire logic edge_time_mode,
  input wire logic match_allow,
  input wire logic timeout_evt,
  input wire logic match_evt,
  input wire logic cap_event_evt,
  input wire logic cap_match_evt,
  output logic timeout_set,
  output logic match_set,
  output logic cap_event_set,
  output logic cap_match_set
);
  // Count-mode events only in one-shot or periodic, capture in edge-time
  assign timeout_set = timeout_evt && !edge_time_mode;
  assign match_set = match_evt && !edge_time_mode && match_allow;
  assign cap_event_set = cap_event_evt && edge_time_mode;
  assign cap_match_set = cap_match_evt && edge_time_mode;
endmodule // tims_sub_events
`default_nettype wire

//--- rtl/tims_irq.sv
// Timer interrupt mask, raw status and masked status registers
`timescale 1ns/100ps
`default_nettype none
module tims_irq
  import tims_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [tims_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tims_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tims_pkg::DATA_W-1:0] reg_rdata,
  input wire logic sub_a_timeout_evt,
  input wire logic sub_a_match_evt,
  input wire logic sub_a_capture_event_evt,
  input wire logic sub_a_capture_match_evt,
  input wire logic sub_a_dma_done_evt,
  input wire logic sub_b_timeout_evt,
  input wire logic sub_b_match_evt,
  input wire logic sub_b_capture_event_evt,
  input wire logic sub_b_capture_match_evt,
  input wire logic sub_b_dma_done_evt,
  output logic timer_irq
);
  import tims_pkg::*;

  logic [NSRC-1:0] mask_q;
  logic [NSRC-1:0] raw_q;
  logic [NSRC-1:0] raw_d;
  logic [NSRC-1:0] set_vec;
  logic [NSRC-1:0] clr_vec;
  logic [NSRC-1:0] masked;
  logic [DATA_W-1:0] mode_q;
  logic [DATA_W-1:0] rdata_q;

  logic wr_mask;
  logic wr_clear;
  logic wr_mode;

  // Write decode
  assign wr_mask = reg_wr && (reg_addr == OFF_IRQ_ENABLE_MASK);
  assign wr_clear = reg_wr && (reg_addr == OFF_IRQ_CLEAR);
  assign wr_mode = reg_wr && (reg_addr == OFF_MODE_CTRL);

  // Enable mask register, reserved bits never stored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_q <= IRQ_RESET;
    end else if (wr_mask) begin
      mask_q <= reg_wdata[NSRC-1:0] & IRQ_IMPL_BITS;
    end
  end

  // Sub-timer mode control
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= MODE_RESET;
    end else if (wr_mode) begin
      mode_q <= reg_wdata & MODE_IMPL_BITS;
    end
  end

  // Sub-timer A event qualification
  tims_sub_events u_sub_a (
    .periodic_mode(mode_q[MODE_A_PERIODIC]),
    .edge_time_mode(mode_q[MODE_A_EDGE_TIME]),
    .match_allow(mode_q[MODE_A_MATCH_ALLOW]),
    .timeout_evt(sub_a_timeout_evt),
    .match_evt(sub_a_match_evt),
    .cap_event_evt(sub_a_capture_event_evt),
    .cap_match_evt(sub_a_capture_match_evt),
    .timeout_set(set_vec[SUB_A_TIMEOUT]),
    .match_set(set_vec[SUB_A_MATCH]),
    .cap_event_set(set_vec[SUB_A_CAP_EVENT]),
    .cap_match_set(set_vec[SUB_A_CAP_MATCH])
  );

  // Sub-timer B event qualification
  tims_sub_events u_sub_b (
    .periodic_mode(mode_q[MODE_B_PERIODIC]),
    .edge_time_mode(mode_q[MODE_B_EDGE_TIME]),
    .match_allow(mode_q[MODE_B_MATCH_ALLOW]),
    .timeout_evt(sub_b_timeout_evt),
    .match_evt(sub_b_match_evt),
    .cap_event_evt(sub_b_capture_event_evt),
    .cap_match_evt(sub_b_capture_match_evt),
    .timeout_set(set_vec[SUB_B_TIMEOUT]),
    .match_set(set_vec[SUB_B_MATCH]),
    .cap_event_set(set_vec[SUB_B_CAP_EVENT]),
    .cap_match_set(set_vec[SUB_B_CAP_MATCH])
  );

  // DMA done and reserved set terms
  assign set_vec[SUB_A_DMA_DONE] = sub_a_dma_done_evt;
  assign set_vec[SUB_B_DMA_DONE] = sub_b_dma_done_evt;
  assign set_vec[3] = 1'b0;
  assign set_vec[7:6] = 2'b00;
  assign set_vec[12] = 1'b0;

  // Write-one-to-clear vector
  assign clr_vec = wr_clear ? (reg_wdata[NSRC-1:0] & IRQ_IMPL_BITS)
                            : IRQ_RESET;

  // Raw status next value, set wins over clear, mask not applied
  assign raw_d = ((raw_q & ~clr_vec) | set_vec) & IRQ_IMPL_BITS;

  // Raw status register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      raw_q <= IRQ_RESET;
    end else begin
      raw_q <= raw_d;
    end
  end

  // Masked status and interrupt line
  assign masked = raw_q & mask_q;
  assign timer_irq = |masked;

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= READ_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFF_IRQ_ENABLE_MASK: rdata_q <= {18'h00000, mask_q};
        OFF_IRQ_RAW_STATUS: rdata_q <= {18'h00000, raw_q};
        OFF_IRQ_MASKED_STATUS: rdata_q <= {18'h00000, masked};
        OFF_MODE_CTRL: rdata_q <= mode_q;
        default: rdata_q <= READ_ZERO;
      endcase
    end else begin
      rdata_q <= READ_ZERO;
    end
  end

  assign reg_rdata = rdata_q;
endmodule // tims_irq
`default_nettype wire

//--- testbench/tims_irq_monitor.sv
// Checker bound to the timer interrupt block
`timescale 1ns/100ps
`default_nettype none
module tims_irq_monitor
  import tims_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [tims_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tims_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [tims_pkg::DATA_W-1:0] reg_rdata,
  input wire logic sub_a_dma_done_evt,
  input wire logic sub_b_dma_done_evt,
  input wire logic timer_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Read port, reserved bits and unmapped places
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == READ_ZERO)
    else $error("read data not zero outside a read");
  a_rsvd_zero: assert property ($past(reg_rd) &&
    $past(reg_addr) inside {8'h18, 8'h1C, 8'h20} |->
    (reg_rdata & ~32'h0000_2F37) == READ_ZERO)
    else $error("reserved bit reads one");
  a_unmapped_zero: assert property ($past(reg_rd) &&
    !($past(reg_addr) inside {8'h18, 8'h1C, 8'h20, 8'h28}) |->
    reg_rdata == READ_ZERO)
    else $error("unmapped read not zero");
  // Mask register, interrupt output and DMA done raw status
  a_mask_readback: assert property ((reg_wr && reg_addr == 8'h18) ##1
    (reg_rd && reg_addr == 8'h18) |=>
    reg_rdata == ($past(reg_wdata, 2) & 32'h0000_2F37))
    else $error("mask read back differs");
  a_irq_reset: assert property ($fell(sys_rst) |-> !timer_irq && reg_rdata == READ_ZERO)
    else $error("outputs not clear after reset");
  a_mask_off_quiet: assert property (reg_wr && reg_addr == 8'h18 &&
    reg_wdata == READ_ZERO |=> !timer_irq)
    else $error("interrupt with all sources masked");
  a_dma_a_irq: assert property ((reg_wr && reg_addr == 8'h18 &&
    reg_wdata[5]) ##1 (sub_a_dma_done_evt && !reg_wr) |=> timer_irq)
    else $error("enabled source did not raise interrupt");
  a_dma_b_raw: assert property (sub_b_dma_done_evt ##1
    (reg_rd && reg_addr == 8'h1C) |=> reg_rdata[13])
    else $error("dma done raw bit not set");
endmodule // tims_irq_monitor
bind tims_irq tims_irq_monitor tims_irq_monitor_inst (.clk, .sys_rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .sub_a_dma_done_evt, .sub_b_dma_done_evt, .timer_irq);
`default_nettype wire

//--- testbench/tb_top.sv
// Random and directed bench of the timer interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tims_pkg::*;
  logic clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, timer_irq;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata, d, b;
  logic [9:0] evt = 10'h000;
  int n_mismatch = 0, cmp_count = 0, k;
  int pos[10] = '{0, 1, 2, 4, 5, 8, 9, 10, 11, 13};
  tims_irq tims_irq_inst (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .timer_irq, .sub_a_timeout_evt(evt[0]),
    .sub_a_capture_match_evt(evt[1]), .sub_a_capture_event_evt(evt[2]),
    .sub_a_match_evt(evt[3]), .sub_a_dma_done_evt(evt[4]),
    .sub_b_timeout_evt(evt[5]), .sub_b_capture_match_evt(evt[6]),
    .sub_b_capture_event_evt(evt[7]), .sub_b_match_evt(evt[8]),
    .sub_b_dma_done_evt(evt[9]));
  // Clock and safety stop
  initial forever #5 clk = ~clk;
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic pulse(input int i);
    evt[i] <= 1'h1;
    @(posedge clk);
    evt[i] <= 1'h0;
    #1;
  endtask
  // Raw bit expected after an event: set when qualified, DMA always
  function automatic logic [31:0] raw_exp(int k, int g, logic [31:0] b);
    return (g == 1 || k == 4) ? b : 32'h0;
  endfunction
  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Reset, register traffic, then each source in both modes
  initial begin
    void'($urandom(85354));
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    #1 rd(OFF_IRQ_ENABLE_MASK, 32'h0);
    rd(OFF_IRQ_RAW_STATUS, 32'h0);
    rd(OFF_IRQ_MASKED_STATUS, 32'h0);
    rd(8'h30, 32'h0);
    repeat (20) begin
      d = $urandom;
      wr(OFF_IRQ_ENABLE_MASK, d);
      rd(OFF_IRQ_ENABLE_MASK, d & 32'h0000_2F37);
      wr(OFF_IRQ_RAW_STATUS, d);
      rd(OFF_IRQ_RAW_STATUS, 32'h0);
    end
    for (int i = 0; i < 10; i++) begin
      b = 32'h1 << pos[i];
      k = i % 5;
      wr(OFF_IRQ_ENABLE_MASK, 32'h0);
      wr(OFF_IRQ_CLEAR, 32'h0000_3FFF);
      for (int g = 0; g < 2; g++) begin
        wr(OFF_MODE_CTRL, ((k == 1 || k == 2) == (g == 1)) ? 32'h606 : 32'h404);
        pulse(i);
        rd(OFF_IRQ_RAW_STATUS, raw_exp(k, g, b));
      end
      chk(timer_irq, 32'h0);
      wr(OFF_IRQ_ENABLE_MASK, b);
      chk(timer_irq, 32'h1);
      rd(OFF_IRQ_MASKED_STATUS, b);
      wr(OFF_IRQ_CLEAR, b);
      rd(OFF_IRQ_RAW_STATUS, 32'h0);
    end
    wr(OFF_IRQ_ENABLE_MASK, 32'h20);
    pulse(4);
    chk(timer_irq, 32'h1);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
